// ===== logic/pfd_pkg.sv
package pfd_pkg;
    // Register indices; the byte address is index * 4
    localparam logic [11:0] REF_LOW_IDX     = 12'h011;
    localparam logic [11:0] REF_HIGH_IDX    = 12'h012;
    localparam logic [11:0] SWALLOW_IDX     = 12'h013;
    localparam logic [11:0] MAIN_LOW_IDX    = 12'h014;
    localparam logic [11:0] MAIN_HIGH_IDX   = 12'h015;
    localparam logic [11:0] DIV_CTRL_IDX    = 12'h016;
    localparam logic [11:0] STAT_SEL_IDX    = 12'h017;
    localparam logic [11:0] STATE_IDX       = 12'h018;
    localparam logic [11:0] PIN_CTRL_IDX    = 12'h01D;
    localparam int          ADDR_SHIFT      = 2;

    // Reset values
    localparam logic [7:0] SWALLOW_RST   = 8'h00;
    localparam logic [7:0] MAIN_LOW_RST  = 8'h03;
    localparam logic [7:0] MAIN_HIGH_RST = 8'h00;
    localparam logic [7:0] REF_LOW_RST   = 8'h01;
    localparam logic [7:0] REF_HIGH_RST  = 8'h00;
    localparam logic [7:0] DIV_CTRL_RST  = 8'h06;
    localparam logic [7:0] STAT_SEL_RST  = 8'h00;
    localparam logic [7:0] PIN_CTRL_RST  = 8'h00;

    // Field layout
    localparam int SWALLOW_W      = 6;
    localparam int MAIN_HIGH_W    = 5;
    localparam int REF_HIGH_W     = 6;
    localparam int MAIN_W         = 13;
    localparam int REF_W          = 14;
    localparam int BIT_REF_RST    = 6;
    localparam int BIT_AB_RST     = 5;
    localparam int BIT_ALL_RST    = 4;
    localparam int BIT_BYPASS     = 3;
    localparam int BIT_SEL_LOCK   = 7;
    localparam int PRE_W          = 3;
    localparam int SEL_LSB        = 2;

    // Prescaler codes
    localparam logic [2:0] PRE_FD1  = 3'h0;
    localparam logic [2:0] PRE_FD2  = 3'h1;
    localparam logic [2:0] PRE_DM2  = 3'h2;
    localparam logic [2:0] PRE_DM4  = 3'h3;
    localparam logic [2:0] PRE_DM8  = 3'h4;
    localparam logic [2:0] PRE_DM16 = 3'h5;
    localparam logic [2:0] PRE_DM32 = 3'h6;
    localparam logic [2:0] PRE_FD3  = 3'h7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Most significant field first: bit 7 down to bits 2:0
    typedef struct packed {
        logic       midSupply;
        logic       holdRef;
        logic       holdSwallowMain;
        logic       holdAll;
        logic       bypass;
        logic [2:0] prescaler;
    } pfd_ctrl_t;

    typedef struct packed {
        logic [SWALLOW_W-1:0] swallow;
        logic [MAIN_W-1:0]    mainCount;
        logic [REF_W-1:0]     refCount;
    } pfd_counts_t;
endpackage

// ===== logic/pfd_down_counter.sv
`timescale 1ns/100ps
`default_nettype none
// Reloading down counter; terminal pulse at count one (or zero), where it reloads
module pfd_down_counter
#(
    parameter int W = 8
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         clkEn,
    // Control
    input  wire logic         hold,
    input  wire logic         load,
    input  wire logic [W-1:0] loadValue,
    // Status
    output logic [W-1:0]      count,
    output logic              terminal
);
    logic [W-1:0] countReg;
    logic [W-1:0] countNext;

    assign terminal  = !hold && (countReg <= W'(1));
    assign countNext = (hold || load || terminal) ? loadValue : countReg - W'(1);
    assign count     = countReg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            countReg <= '0;
        else if (clkEn)
            countReg <= countNext;
    end
endmodule
`default_nettype wire

// ===== logic/pfd_divider_ctrl.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Main count 13 bits: low byte resets 3, upper five bits reset 0.
// - Swallow count six bits in its own register, resets to zero.
// - Reset bits hold counters: 6 reference, 5 swallow/main, 4 all.
// - Bypass bit makes main count divide by one; ratio is the prescaler modulus, plus one in dual modes with swallow nonzero.
// - Prescaler codes 000, 001, 111 are fixed divide by 1, 2, 3.
// - Codes 010-110 dual modulus; higher modulus when swallow nonzero.
// - Prescaler resets to 32/33 dual modulus setting.
// - Reference divider 14 bits: low byte resets 1, upper six reset 0.
module pfd_divider_ctrl
    import pfd_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Divider outputs
    output logic             feedbackPulse,
    output logic             refPulse,
    output logic [5:0]       statusSelect
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  swallowReg, mainLowReg, mainHighReg, refLowReg, refHighReg;
    logic [7:0]  divCtrlReg, statSelReg, pinCtrlReg;
    logic [11:0] awAddrReg;
    logic [31:0] wDataReg;
    logic        awHeldReg, wHeldReg, bValidReg, bErrReg, rValidReg;
    logic [1:0]  rRespReg;
    logic [31:0] rDataReg;
    logic        feedbackReg, refPulseReg;

    pfd_ctrl_t   ctrl;
    pfd_counts_t counts;
    assign ctrl = pfd_ctrl_t'(divCtrlReg);
    assign counts.swallow   = swallowReg[SWALLOW_W-1:0];
    assign counts.mainCount = {mainHighReg[MAIN_HIGH_W-1:0], mainLowReg};
    assign counts.refCount  = {refHighReg[REF_HIGH_W-1:0], refLowReg};

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    wire         awTake   = s_axi_awvalid && !awHeldReg && !bValidReg;
    wire         wTake    = s_axi_wvalid && !wHeldReg && !bValidReg;
    wire [11:0]  wAddr    = awHeldReg ? awAddrReg : s_axi_awaddr;
    wire [31:0]  wData    = wHeldReg ? wDataReg : s_axi_wdata;
    wire         awHave   = awHeldReg || awTake;
    wire         wHave    = wHeldReg || wTake;
    wire         doWrite  = awHave && wHave && !bValidReg;
    wire [11:0]  wIdx     = wAddr >> ADDR_SHIFT;
    wire         wLane    = s_axi_wstrb[0];
    wire [7:0]   wByte    = wData[7:0];
    wire         wMapped  = (wIdx >= REF_LOW_IDX && wIdx <= STATE_IDX) || wIdx == PIN_CTRL_IDX;
    wire         wAligned = wAddr[1:0] == 2'h0;
    wire         wOk      = wMapped && wAligned && wIdx != STATE_IDX;
    wire         wrEn     = doWrite && wOk && wLane;
    // Status select writable only while pin-control bit 7 is clear
    wire         selOpen  = !pinCtrlReg[BIT_SEL_LOCK];

    assign s_axi_awready = !awHeldReg && !bValidReg;
    assign s_axi_wready  = !wHeldReg && !bValidReg;
    assign s_axi_bvalid  = bValidReg;
    assign s_axi_bresp   = bErrReg ? RESP_SLVERR : RESP_OKAY;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHeldReg <= 1'b0;
            wHeldReg  <= 1'b0;
            awAddrReg <= 12'h000;
            wDataReg  <= 32'h00000000;
            bValidReg <= 1'b0;
            bErrReg   <= 1'b0;
        end
        else if (clkEn)
        begin
            if (awTake)
                awAddrReg <= s_axi_awaddr;
            if (wTake)
                wDataReg <= s_axi_wdata;
            awHeldReg <= awHave && !doWrite;
            wHeldReg  <= wHave && !doWrite;
            if (doWrite)
            begin
                bValidReg <= 1'b1;
                bErrReg   <= !(wMapped && wAligned);
            end
            else if (s_axi_bready)
                bValidReg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            swallowReg  <= SWALLOW_RST;
            mainLowReg  <= MAIN_LOW_RST;
            mainHighReg <= MAIN_HIGH_RST;
            refLowReg   <= REF_LOW_RST;
            refHighReg  <= REF_HIGH_RST;
            divCtrlReg  <= DIV_CTRL_RST;
            statSelReg  <= STAT_SEL_RST;
            pinCtrlReg  <= PIN_CTRL_RST;
        end
        else if (clkEn && wrEn)
        begin
            unique case (wIdx)
                SWALLOW_IDX:   swallowReg  <= {2'h0, wByte[SWALLOW_W-1:0]};
                MAIN_LOW_IDX:  mainLowReg  <= wByte;
                MAIN_HIGH_IDX: mainHighReg <= {3'h0, wByte[MAIN_HIGH_W-1:0]};
                REF_LOW_IDX:   refLowReg   <= wByte;
                REF_HIGH_IDX:  refHighReg  <= {2'h0, wByte[REF_HIGH_W-1:0]};
                DIV_CTRL_IDX:  divCtrlReg  <= wByte;
                STAT_SEL_IDX:  if (selOpen) statSelReg <= {wByte[7:SEL_LSB], 2'h0};
                PIN_CTRL_IDX:  pinCtrlReg  <= wByte;
                default:       pinCtrlReg  <= pinCtrlReg;
            endcase
        end
    end
    assign statusSelect = statSelReg[7:SEL_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Read channel; one-cycle answer
    wire [11:0] rIdx    = s_axi_araddr >> ADDR_SHIFT;
    wire        rOk     = s_axi_araddr[1:0] == 2'h0
                          && ((rIdx >= REF_LOW_IDX && rIdx <= STATE_IDX) || rIdx == PIN_CTRL_IDX);
    wire [5:0]  swallowNow;
    logic [7:0] rByte;
    always_comb
    begin
        unique case (rIdx)
            REF_LOW_IDX:   rByte = refLowReg;
            REF_HIGH_IDX:  rByte = refHighReg;
            SWALLOW_IDX:   rByte = swallowReg;
            MAIN_LOW_IDX:  rByte = mainLowReg;
            MAIN_HIGH_IDX: rByte = mainHighReg;
            DIV_CTRL_IDX:  rByte = divCtrlReg;
            STAT_SEL_IDX:  rByte = statSelReg;
            STATE_IDX:     rByte = {feedbackReg, refPulseReg, swallowNow};
            PIN_CTRL_IDX:  rByte = pinCtrlReg;
            default:       rByte = 8'h00;
        endcase
    end
    assign s_axi_arready = !rValidReg;
    assign s_axi_rvalid  = rValidReg;
    assign s_axi_rdata   = rDataReg;
    assign s_axi_rresp   = rRespReg;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rValidReg <= 1'b0;
            rDataReg  <= 32'h00000000;
            rRespReg  <= RESP_OKAY;
        end
        else if (clkEn)
        begin
            if (s_axi_arvalid && !rValidReg)
            begin
                rValidReg <= 1'b1;
                rDataReg  <= {24'h000000, rOk ? rByte : 8'h00};
                rRespReg  <= rOk ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                rValidReg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Feedback divider: prescaler, swallow and main counters
    wire holdRef = ctrl.holdRef || ctrl.holdAll;
    wire holdAB  = ctrl.holdSwallowMain || ctrl.holdAll;
    wire isDual  = ctrl.prescaler inside {[PRE_DM2:PRE_DM32]};
    logic [5:0] lowMod;
    always_comb
    begin
        unique case (ctrl.prescaler)
            PRE_FD1:  lowMod = 6'h01;
            PRE_FD2:  lowMod = 6'h02;
            PRE_DM2:  lowMod = 6'h02;
            PRE_DM4:  lowMod = 6'h04;
            PRE_DM8:  lowMod = 6'h08;
            PRE_DM16: lowMod = 6'h10;
            PRE_DM32: lowMod = 6'h20;
            PRE_FD3:  lowMod = 6'h03;
        endcase
    end

    // Swallow phase uses the higher modulus while any swallow is pending
    wire        swallowLeft = isDual && swallowNow != 6'h00;
    wire [5:0]  preMod  = swallowLeft ? lowMod + 6'h01 : lowMod;
    wire        preTerm;
    wire        mainTerm;
    wire        mainTick;
    wire [12:0] mainLoad = ctrl.bypass ? 13'h0001 : counts.mainCount;
    wire        cycleEnd = preTerm && (mainLoad <= 13'h0001 || mainTerm);

    pfd_down_counter #(.W(6)) preCounter (
        .clk       (ref_clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .hold      (holdAB),
        .load      (1'b0),
        .loadValue (preMod),
        .count     (),
        .terminal  (preTerm)
    );

    assign mainTick = preTerm;
    pfd_down_counter #(.W(13)) mainCounter (
        .clk       (ref_clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn && (mainTick || holdAB)),
        .hold      (holdAB),
        .load      (1'b0),
        .loadValue (mainLoad),
        .count     (),
        .terminal  (mainTerm)
    );

    // Swallow counts down once per prescaler cycle, reloads at feedback end
    logic [5:0] swallowCntReg;
    assign swallowNow = swallowCntReg;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            swallowCntReg <= 6'h00;
        else if (clkEn)
        begin
            if (holdAB || cycleEnd)
                swallowCntReg <= counts.swallow;
            else if (preTerm && swallowCntReg != 6'h00)
                swallowCntReg <= swallowCntReg - 6'h01;
        end
    end

    // Reference divider
    wire refTerm;
    pfd_down_counter #(.W(REF_W)) refCounter (
        .clk       (ref_clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .hold      (holdRef),
        .load      (1'b0),
        .loadValue (counts.refCount),
        .count     (),
        .terminal  (refTerm)
    );

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            feedbackReg <= 1'b0;
            refPulseReg <= 1'b0;
        end
        else if (clkEn)
        begin
            feedbackReg <= cycleEnd && !holdAB;
            refPulseReg <= refTerm;
        end
    end
    assign feedbackPulse = feedbackReg;
    assign refPulse      = refPulseReg;
endmodule
`default_nettype wire

// ===== dv/pfd_divider_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pfd_divider_ctrl_chk
    import pfd_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset_n,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Divider outputs
    input wire logic        feedbackPulse,
    input wire logic        refPulse,
    input wire logic [5:0]  statusSelect
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    bhold_stable_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rhold_stable_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    err_data_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read carries data");
    status_write_a: assert property ($changed(statusSelect) |-> s_axi_bvalid)
        else $error("status select changed without write");

    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    cover property (feedbackPulse);
    cover property (refPulse);
endmodule
bind pfd_divider_ctrl pfd_divider_ctrl_chk chk_u (.ref_clk, .reset_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .feedbackPulse, .refPulse, .statusSelect);
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import pfd_pkg::*;
;
    localparam logic [11:0] RST_ADDR [6] = '{12'h044, 12'h048, 12'h04C, 12'h050, 12'h054, 12'h058};
    localparam logic [7:0]  RST_VAL [6]  = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06};
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        clkEn = 1'b1;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, fb, rp;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [5:0]  stSel;
    int          failures = 0;
    int          checks = 0;

    always #12.5 ref_clk = ~ref_clk;

    pfd_divider_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .feedbackPulse(fb), .refPulse(rp), .statusSelect(stSel));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
        logic aw, w, b;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge ref_clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            resp = bresp;
            @(posedge ref_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        while (!b);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar, r;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge ref_clk);
            ar = arvalid && arready;
            r = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge ref_clk);
            if (ar) arvalid <= 1'b0;
        end
        while (!r);
        rready <= 1'b0;
    endtask

    // Third interval: first is partial, second may span a reload
    task automatic period(output int p);
        repeat (3)
        begin
            p = 0;
            do
            begin
                @(negedge ref_clk);
                p++;
            end
            while (!fb && p < 2000);
        end
    endtask

    task automatic pulses(output int nf, output int nr);
        nf = 0;
        nr = 0;
        repeat (4) @(negedge ref_clk);
        repeat (300)
        begin
            @(negedge ref_clk);
            nf += fb;
            nr += rp;
        end
    endtask

    function automatic int expPeriod(logic [2:0] pre, int m, int a);
        case (pre)
            PRE_FD1: return m;
            PRE_FD2: return 2 * m;
            PRE_FD3: return 3 * m;
            default: return (1 << (pre - 1)) * m + a;
        endcase
    endfunction

    task automatic wrap_up;
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        wrap_up();
    end

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        int          p, nf, nr, m, a;
        void'($urandom(17107));
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            rd(RST_ADDR[i], d, r);
            chk("reset value", d, {24'h0, RST_VAL[i]});
        end
        period(p);
        chk("default period", p, expPeriod(PRE_DM32, 3, 0));
        rd(12'h0FC, d, r);
        chk("unmapped data", d, 32'h0);
        chk("unmapped read", r, RESP_SLVERR);
        wr(12'h0FC, 8'h5A, r);
        chk("unmapped write", r, RESP_SLVERR);
        // Hold bits 4, 5, 6 one at a time
        for (int i = 4; i < 7; i++)
        begin
            wr(12'h058, 8'h06 | (8'h01 << i), r);
            pulses(nf, nr);
            chk("feedback running", nf != 0, i == 6);
            chk("reference running", nr != 0, i == 5);
        end
        wr(12'h054, 8'h1F, r);
        rd(12'h054, d, r);
        chk("main high", d, 32'h1F);
        wr(12'h054, 8'h00, r);
        // Every prescaler code with random counts
        for (int i = 0; i < 8; i++)
        begin
            m = $urandom_range(9, 2);
            a = $urandom_range(m - 1, 0);
            wr(12'h04C, a[7:0], r);
            wr(12'h050, m[7:0], r);
            wr(12'h058, {5'h0, i[2:0]}, r);
            period(p);
            chk("period", p, expPeriod(i[2:0], m, a));
            rd(12'h04C, d, r);
            chk("swallow", d, a);
        end
        wr(12'h04C, 8'h00, r);
        wr(12'h058, 8'h0B, r);
        period(p);
        chk("bypass period", p, expPeriod(PRE_DM4, 1, 0));
        // Clock enable low freezes the divider
        @(posedge ref_clk);
        clkEn <= 1'b0;
        pulses(nf, nr);
        chk("frozen feedback", nf % 300, 0);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        wr(12'h05C, 8'hA4, r);
        chk("status select", stSel, 6'h29);
        wr(12'h074, 8'h80, r);
        wr(12'h05C, 8'h10, r);
        chk("status locked", stSel, 6'h29);
        wrap_up();
    end
endmodule
`default_nettype wire
